// ---- src/sts_pkg.sv ----
package sts_pkg;
    // candidate layout: line-rate inputs first, then 2 048 kbit/s inputs
    localparam int N_STM = 2;
    localparam int N_E1  = 2;
    localparam int N_EXT = N_STM + N_E1;
    localparam int IDX_W = 2;
    localparam int QL_W  = 4;
    localparam int PRIO_W = 3;
    localparam int BYTE_W = 8;

    // status message handling
    localparam logic [QL_W-1:0]   QL_DO_NOT_USE = 4'hf;
    localparam logic [BYTE_W-1:0] S1_ALL_ONES   = 8'hff;
    localparam int                S1_QL_LSB     = 0;

    // rates in kHz (bit rates in kbit/s) and the system clock
    localparam longint CLK_KHZ     = 250000;
    localparam longint BYTE_KHZ    = 19440;
    localparam longint TRIB_KHZ    = 2048;
    localparam int     NCO_W       = 32;
    localparam logic [NCO_W-1:0] BYTE_INC =
        NCO_W'((BYTE_KHZ << NCO_W) / CLK_KHZ);
    localparam logic [NCO_W-1:0] TRIB_INC =
        NCO_W'((TRIB_KHZ << NCO_W) / CLK_KHZ);
    localparam logic [NCO_W-1:0] SMOOTH_TRIM = 32'h0000_4000;

    // distributed frame: bytes per frame, counter width
    localparam int                FRM_W      = 12;
    localparam logic [FRM_W-1:0]  FRAME_LAST = 12'(2430 - 1);

    // recovered frame alignment word (two bytes)
    localparam logic [BYTE_W-1:0] ALIGN_B1 = 8'hf6;
    localparam logic [BYTE_W-1:0] ALIGN_B2 = 8'h28;

    // smoothing store occupancy
    localparam int               FILL_W   = 4;
    localparam logic [FILL_W-1:0] FILL_MID = 4'h8;
    localparam logic [FILL_W-1:0] FILL_MAX = 4'hf;

    // ais oscillators: ms, 140M, 34M, 8M, 2M, 64k (rates in kbit/s)
    localparam int N_AIS = 6;
    localparam longint AIS_KHZ [N_AIS] =
        '{155520, 139264, 34368, 8448, 2048, 64};
    localparam int AIS_PPM [N_AIS] = '{20, 15, 20, 30, 50, 100};

    // source ais clock choices: high order, four tributary layers, oscs
    localparam int N_LAYER = 4;
    localparam int N_SRC_AIS = 1 + N_LAYER + N_AIS;
    localparam int SRC_SEL_W = 4;
endpackage : sts_pkg

// ---- src/sts_sel_if.sv ----
`timescale 1ns/1ps
interface sts_sel_if;
    logic [sts_pkg::N_EXT-1:0]              usable;
    logic [sts_pkg::N_EXT*sts_pkg::QL_W-1:0]   quality;
    logic [sts_pkg::N_EXT*sts_pkg::PRIO_W-1:0] prio;
    logic [sts_pkg::IDX_W-1:0]              sel_idx;
    logic                                   sel_valid;

    modport feed (output usable, quality, prio, input sel_idx, sel_valid);
    modport pick (input usable, quality, prio, output sel_idx, sel_valid);
endinterface : sts_sel_if

// ---- src/sts_select.sv ----
`timescale 1ns/1ps
module sts_select (
    input  wire logic  clock_i,
    input  wire logic  rst_i,
    sts_sel_if.pick    sel
);
    logic [sts_pkg::QL_W-1:0]   best_q;
    logic [sts_pkg::PRIO_W-1:0] best_p;
    logic [sts_pkg::IDX_W-1:0]  best_i;
    logic                       found;
    logic [sts_pkg::IDX_W-1:0]  sel_idx_r;
    logic                       sel_valid_r;

    // drop defective and do-not-use inputs, best quality then priority
    always_comb
    begin
        logic [sts_pkg::QL_W-1:0]   q;
        logic [sts_pkg::PRIO_W-1:0] p;
        q = '0;
        p = '0;
        best_q = sts_pkg::QL_DO_NOT_USE;
        best_p = '1;
        best_i = '0;
        found  = 1'b0;
        for (int i = 0; i < sts_pkg::N_EXT; i++)
        begin
            q = sel.quality[i*sts_pkg::QL_W +: sts_pkg::QL_W];
            p = sel.prio[i*sts_pkg::PRIO_W +: sts_pkg::PRIO_W];
            if (sel.usable[i] && q != sts_pkg::QL_DO_NOT_USE &&
                (!found || q < best_q || (q == best_q && p < best_p)))
            begin
                best_q = q;
                best_p = p;
                best_i = sts_pkg::IDX_W'(i);
                found  = 1'b1;
            end
        end
    end

    // result held in flops so it changes once per clock
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_idx_r   <= '0;
            sel_valid_r <= 1'b0;
        end
        else
        begin
            sel_idx_r   <= best_i;
            sel_valid_r <= found;
        end
    end

    assign sel.sel_idx   = sel_idx_r;
    assign sel.sel_valid = sel_valid_r;
endmodule : sts_select

// ---- src/sts_timing_top.sv ----
`timescale 1ns/1ps
module sts_timing_top (
    input  wire logic                                  clock_i,
    input  wire logic                                  rst_i,
    input  wire logic [sts_pkg::N_EXT-1:0]             ref_tick_i,
    input  wire logic [sts_pkg::N_EXT-1:0]             ref_defect_i,
    input  wire logic [sts_pkg::N_EXT-1:0]             ref_enable_i,
    input  wire logic [sts_pkg::N_EXT-1:0]             refout_enable_i,
    input  wire logic [sts_pkg::N_STM*8-1:0]           stm_s1_i,
    input  wire logic [sts_pkg::N_E1*4-1:0]            e1_quality_i,
    input  wire logic [sts_pkg::N_EXT*3-1:0]           ref_prio_i,
    input  wire logic                                  sink_clock_i,
    input  wire logic                                  sink_fs_i,
    input  wire logic [7:0]                            adapted_data_i,
    input  wire logic                                  sink_oh_i,
    input  wire logic                                  sink_align_en_i,
    input  wire logic                                  sink_ais_i,
    input  wire logic                                  term_clock_i,
    input  wire logic                                  term_fs_i,
    input  wire logic                                  ho_ti_clock_i,
    input  wire logic [sts_pkg::N_LAYER-1:0]           tu_ti_clock_i,
    input  wire logic [3:0]                            src_ais_sel_i,
    output logic                                       dist_timing_clock_o,
    output logic                                       dist_frame_start_o,
    output logic                                       sys_internal_o,
    output logic [sts_pkg::IDX_W-1:0]                  sys_sel_idx_o,
    output logic                                       refout_tick_o,
    output logic                                       refout_valid_o,
    output logic [sts_pkg::IDX_W-1:0]                  refout_sel_idx_o,
    output logic                                       unequipped_valid_o,
    output logic [7:0]                                 unequipped_data_o,
    output logic                                       sink_clock_o,
    output logic                                       sink_fs_o,
    output logic [7:0]                                 sink_data_o,
    output logic                                       smooth_clock_o,
    output logic                                       term_clock_o,
    output logic                                       term_fs_o,
    output logic                                       src_ais_clock_o,
    output logic [7:0]                                 src_ais_data_o
);
    sts_sel_if sys_if ();
    sts_sel_if out_if ();

    logic [sts_pkg::N_EXT*sts_pkg::QL_W-1:0]   ql_w;
    logic [sts_pkg::N_EXT-1:0]                 usable_w;
    logic [sts_pkg::NCO_W-1:0]                 byte_acc_r;
    logic [sts_pkg::NCO_W-1:0]                 byte_acc_nxt;
    logic                                      byte_carry_w;
    logic [sts_pkg::FRM_W-1:0]                 frame_cnt_r;
    logic [sts_pkg::FRM_W-1:0]                 frame_cnt_nxt;
    logic                                      sys_tick_w;
    logic                                      frame_wrap_w;
    logic                                      align_b1_r;
    logic                                      align_hit_w;
    logic [sts_pkg::FILL_W-1:0]                fill_r;
    logic [sts_pkg::NCO_W-1:0]                 sm_acc_r;
    logic [sts_pkg::NCO_W-1:0]                 sm_inc_w;
    logic [sts_pkg::NCO_W:0]                   sm_sum_w;
    logic                                      sm_tick_w;
    logic                                      sink_in_w;
    logic [sts_pkg::N_AIS-1:0]                 ais_tick_w;
    logic [sts_pkg::N_SRC_AIS-1:0]             src_ais_w;

    // per input: quality from status byte or configuration, usability
    for (genvar i = 0; i < sts_pkg::N_EXT; i++)
    begin : g_ref
        if (i < sts_pkg::N_STM)
        begin : g_stm
            wire [7:0] s1_w = stm_s1_i[i*8 +: 8];
            assign ql_w[i*sts_pkg::QL_W +: sts_pkg::QL_W] =
                (s1_w == sts_pkg::S1_ALL_ONES) ?
                sts_pkg::QL_DO_NOT_USE :
                s1_w[sts_pkg::S1_QL_LSB +: sts_pkg::QL_W];
        end
        else
        begin : g_e1
            assign ql_w[i*sts_pkg::QL_W +: sts_pkg::QL_W] =
                e1_quality_i[(i-sts_pkg::N_STM)*4 +: 4];
        end
        // traffic state plays no part in enabling an input
        assign usable_w[i] = ref_enable_i[i] & ~ref_defect_i[i];
    end

    // two selectors; the output one adds its own enable mask to the shared one
    assign sys_if.usable  = usable_w;
    assign sys_if.quality = ql_w;
    assign sys_if.prio    = ref_prio_i;
    assign out_if.usable  = usable_w & refout_enable_i;
    assign out_if.quality = ql_w;
    assign out_if.prio    = ref_prio_i;

    sts_select u_sys_sel (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .sel     (sys_if.pick)
    );

    sts_select u_out_sel (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .sel     (out_if.pick)
    );

    // internal oscillator: byte-rate phase accumulator
    assign byte_acc_nxt = byte_acc_r + sts_pkg::BYTE_INC;
    assign byte_carry_w = byte_acc_nxt < byte_acc_r;

    // selected reference marks frame start, else the internal frame runs
    assign sys_tick_w   = sys_if.sel_valid &
                          ref_tick_i[sys_if.sel_idx];
    assign frame_wrap_w = (frame_cnt_r == sts_pkg::FRAME_LAST);
    assign frame_cnt_nxt = sys_tick_w ? '0 :
                           frame_wrap_w ? '0 :
                           frame_cnt_r + sts_pkg::FRM_W'(1);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            byte_acc_r <= '0;
        else
            byte_acc_r <= byte_acc_nxt;
    end

    // frame counter advances on byte ticks or realigns on reference tick
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            frame_cnt_r <= '0;
        else if (byte_carry_w | sys_tick_w)
            frame_cnt_r <= frame_cnt_nxt;
    end

    // distributed timing and consumers of it
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dist_timing_clock_o <= 1'b0;
            dist_frame_start_o  <= 1'b0;
            unequipped_valid_o  <= 1'b0;
            unequipped_data_o   <= '0;
        end
        else
        begin
            dist_timing_clock_o <= byte_carry_w;
            dist_frame_start_o  <= byte_carry_w &
                                   frame_cnt_nxt == '0;
            unequipped_valid_o  <= byte_carry_w;
            unequipped_data_o   <= '0;
        end
    end

    // selector results and reference output
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sys_internal_o   <= 1'b1;
            sys_sel_idx_o    <= '0;
            refout_tick_o    <= 1'b0;
            refout_valid_o   <= 1'b0;
            refout_sel_idx_o <= '0;
        end
        else
        begin
            sys_internal_o   <= ~sys_if.sel_valid;
            sys_sel_idx_o    <= sys_if.sel_idx;
            refout_tick_o    <= out_if.sel_valid &
                                ref_tick_i[out_if.sel_idx];
            refout_valid_o   <= out_if.sel_valid;
            refout_sel_idx_o <= out_if.sel_idx;
        end
    end

    // recovered frame start: two-byte alignment word on adapted data
    assign align_hit_w = sink_clock_i & align_b1_r &
                         (adapted_data_i == sts_pkg::ALIGN_B2);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            align_b1_r <= 1'b0;
        else if (sink_clock_i)
            align_b1_r <= adapted_data_i == sts_pkg::ALIGN_B1;
    end

    // sink path: clock gapped over overhead, ais on the input clock
    assign sink_in_w = sink_clock_i & ~sink_oh_i;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sink_clock_o <= 1'b0;
            sink_fs_o    <= 1'b0;
            sink_data_o  <= '0;
        end
        else
        begin
            sink_clock_o <= sink_in_w;
            sink_fs_o    <= sink_align_en_i ? align_hit_w :
                            sink_fs_i;
            if (sink_clock_i)
                sink_data_o <= sink_ais_i ? 8'hff :
                               adapted_data_i;
        end
    end

    // smoothing: store occupancy trims an even-rate accumulator
    assign sm_inc_w = (fill_r > sts_pkg::FILL_MID) ?
                      sts_pkg::TRIB_INC + sts_pkg::SMOOTH_TRIM :
                      (fill_r < sts_pkg::FILL_MID) ?
                      sts_pkg::TRIB_INC - sts_pkg::SMOOTH_TRIM :
                      sts_pkg::TRIB_INC;
    assign sm_sum_w  = {1'b0, sm_acc_r} + {1'b0, sm_inc_w};
    // emit from an empty store only when a byte arrives in the same cycle
    assign sm_tick_w = sm_sum_w[sts_pkg::NCO_W] &
                       (fill_r != '0 | sink_in_w);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sm_acc_r       <= '0;
            fill_r         <= sts_pkg::FILL_MID;
            smooth_clock_o <= 1'b0;
        end
        else
        begin
            sm_acc_r       <= sm_sum_w[sts_pkg::NCO_W-1:0];
            smooth_clock_o <= sm_tick_w;
            if (sink_in_w & ~sm_tick_w & fill_r != sts_pkg::FILL_MAX)
                fill_r <= fill_r + sts_pkg::FILL_W'(1);
            else if (sm_tick_w & ~sink_in_w)
                fill_r <= fill_r - sts_pkg::FILL_W'(1);
        end
    end

    // termination source timing taken from its access point
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            term_clock_o <= 1'b0;
            term_fs_o    <= 1'b0;
        end
        else
        begin
            term_clock_o <= term_clock_i;
            term_fs_o    <= term_fs_i;
        end
    end

    // ais oscillators: one accumulator each, error far below ppm limits
    for (genvar a = 0; a < sts_pkg::N_AIS; a++)
    begin : g_ais
        localparam logic [sts_pkg::NCO_W-1:0] INC =
            sts_pkg::NCO_W'((sts_pkg::AIS_KHZ[a] << sts_pkg::NCO_W) /
                            sts_pkg::CLK_KHZ);
        logic [sts_pkg::NCO_W-1:0] acc_r;
        wire  [sts_pkg::NCO_W:0]   sum_w = {1'b0, acc_r} + {1'b0, INC};

        always_ff @(posedge clock_i or posedge rst_i)
        begin
            if (rst_i)
                acc_r <= '0;
            else
                acc_r <= sum_w[sts_pkg::NCO_W-1:0];
        end

        assign ais_tick_w[a] = sum_w[sts_pkg::NCO_W];
    end

    // source ais clock: high order, tributary layer, or an oscillator
    assign src_ais_w = {ais_tick_w, tu_ti_clock_i,
                        ho_ti_clock_i};

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            src_ais_clock_o <= 1'b0;
            src_ais_data_o  <= '0;
        end
        else
        begin
            src_ais_clock_o <= (src_ais_sel_i < sts_pkg::SRC_SEL_W'(
                                   sts_pkg::N_SRC_AIS)) &&
                               src_ais_w[src_ais_sel_i];
            src_ais_data_o  <= 8'hff;
        end
    end
endmodule : sts_timing_top

// ---- test/sts_timing_top_asserts.sv ----
`timescale 1ns/1ps
// watches the top ports: sink copy, distribution spacing, ais clocks
module sts_timing_chk (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic [3:0] ref_tick_i,
    input wire logic [3:0] ref_defect_i,
    input wire logic [3:0] ref_enable_i,
    input wire logic       sink_clock_i,
    input wire logic       sink_oh_i,
    input wire logic       sink_ais_i,
    input wire logic [7:0] adapted_data_i,
    input wire logic       term_clock_i,
    input wire logic       term_fs_i,
    input wire logic       ho_ti_clock_i,
    input wire logic [3:0] tu_ti_clock_i,
    input wire logic [3:0] src_ais_sel_i,
    input wire logic       dist_timing_clock_o,
    input wire logic       dist_frame_start_o,
    input wire logic       sys_internal_o,
    input wire logic       refout_tick_o,
    input wire logic       refout_valid_o,
    input wire logic [1:0] refout_sel_idx_o,
    input wire logic       unequipped_valid_o,
    input wire logic [7:0] unequipped_data_o,
    input wire logic       sink_clock_o,
    input wire logic [7:0] sink_data_o,
    input wire logic       smooth_clock_o,
    input wire logic       term_clock_o,
    input wire logic       term_fs_o,
    input wire logic       src_ais_clock_o,
    input wire logic [7:0] src_ais_data_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // all candidates excluded for two samples
    logic [3:0] excl;
    assign excl = ref_defect_i | ~ref_enable_i;

    fallback_internal_a: assert property (&excl && $past(&excl) |=> sys_internal_o)
        else $error("internal oscillator not taken");
    sink_gap_a: assert property (sink_clock_o == $past(sink_clock_i && !sink_oh_i))
        else $error("sink clock not passed or gapped");
    sink_ais_a: assert property (sink_clock_i && !sink_oh_i && sink_ais_i |=> sink_data_o == 8'hff)
        else $error("sink ais data not all ones");
    sink_data_a: assert property (sink_clock_i && !sink_oh_i && !sink_ais_i |=> sink_data_o == $past(adapted_data_i))
        else $error("sink data not passed");
    term_copy_a: assert property (!$past(rst_i) |-> {term_clock_o, term_fs_o} == $past({term_clock_i, term_fs_i}))
        else $error("termination timing not copied");
    fs_on_clock_a: assert property (dist_frame_start_o |-> dist_timing_clock_o)
        else $error("frame start without timing clock");
    clock_space_a: assert property (dist_timing_clock_o |-> ##1 !dist_timing_clock_o [*8] ##[4:5] dist_timing_clock_o)
        else $error("timing clock spacing wrong");
    unequip_time_a: assert property (unequipped_valid_o == dist_timing_clock_o && unequipped_data_o == 8'h00)
        else $error("unequipped data not on timing clock");
    refout_squelch_a: assert property (!refout_valid_o |-> !refout_tick_o)
        else $error("reference output ticks without source");
    // selected reference tick shows up one cycle later on the output
    refout_tick_a: assert property (refout_tick_o == (refout_valid_o && (($past(ref_tick_i) >> refout_sel_idx_o) & 4'h1) != 4'h0))
        else $error("reference output tick not from selected input");
    smooth_even_a: assert property (smooth_clock_o |=> !smooth_clock_o [*8])
        else $error("smoothed clock bunched");
    src_ho_a: assert property (!rst_i && src_ais_sel_i == 4'h0 |=> src_ais_clock_o == $past(ho_ti_clock_i))
        else $error("au ais clock wrong");
    src_tu_a: assert property (src_ais_sel_i inside {[4'h1:4'h4]} |=> src_ais_clock_o == $past(tu_ti_clock_i[src_ais_sel_i - 4'h1]))
        else $error("tu ais clock wrong");
    src_none_a: assert property (src_ais_sel_i > 4'ha |=> !src_ais_clock_o)
        else $error("ais clock on unused code");
    ais_ones_a: assert property (!$past(rst_i) |-> src_ais_data_o == 8'hff)
        else $error("source ais data not all ones");

    cover property ($fell(sys_internal_o));
    cover property (dist_frame_start_o);
    cover property (refout_tick_o);
    cover property (sink_clock_i && sink_ais_i);
endmodule : sts_timing_chk

bind sts_timing_top sts_timing_chk u_chk (.*);

// ---- test/sts_ref_model.sv ----
`timescale 1ns/1ps
// far-side references: frame ticks and line status bytes
module sts_ref_model (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  ql_i,
    input  wire logic [1:0]  ais_i,
    output logic      [3:0]  tick_o,
    output logic      [15:0] s1_o
);
    int cnt_r [4] = '{0, 0, 0, 0};
    initial tick_o = 4'h0;

    // each reference ticks at its own short period, one cycle wide
    always @(posedge clock_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            cnt_r[i] <= (rst_i || cnt_r[i] >= 40 + 9 * i) ? 0 : cnt_r[i] + 1;
            tick_o[i] <= !rst_i && cnt_r[i] == 40 + 9 * i;
        end
    end

    // status byte; a failed section sends all ones
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            s1_o[8*i +: 8] = ais_i[i] ? 8'hff : {4'h5, ql_i[4*i +: 4]};
    end
endmodule : sts_ref_model

// ---- test/sdh_sync_timing_select_distribute_bench.sv ----
`timescale 1ns/1ps
module sdh_sync_timing_select_distribute_bench;
    logic        clock_i, rst_i, sink_clock_i, sink_fs_i, sink_oh_i;
    logic        sink_align_en_i, sink_ais_i, term_clock_i, term_fs_i;
    logic        ho_ti_clock_i, dist_timing_clock_o, dist_frame_start_o;
    logic        sys_internal_o, refout_tick_o, refout_valid_o, sink_fs_o;
    logic        unequipped_valid_o, sink_clock_o, smooth_clock_o;
    logic        term_clock_o, term_fs_o, src_ais_clock_o;
    logic [3:0]  ref_tick_i, ref_defect_i, ref_enable_i, refout_enable_i;
    logic [3:0]  tu_ti_clock_i, src_ais_sel_i;
    logic [15:0] stm_s1_i, rnd, bgr;
    logic [7:0]  e1_quality_i, adapted_data_i, unequipped_data_o, prev;
    logic [7:0]  sink_data_o, src_ais_data_o, stm_ql;
    logic [11:0] ref_prio_i;
    logic [1:0]  sys_sel_idx_o, refout_sel_idx_o, stm_ais;
    int          n_errors, checks_done, qv [4], pr [4];
    int          cycles = 0;

    sts_timing_top u_dut (.*);
    sts_ref_model u_refs (.clock_i(clock_i), .rst_i(rst_i), .ql_i(stm_ql),
        .ais_i(stm_ais), .tick_o(ref_tick_i), .s1_o(stm_s1_i));

    always #2 clock_i = ~clock_i;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    // selector model: -1 when nothing is usable
    function automatic int pick(input logic [3:0] m);
        int b;
        b = -1;
        for (int i = 0; i < 4; i++)
            if (m[i] && !ref_defect_i[i] && qv[i] != 15 && (b < 0 ||
                qv[i] < qv[b] || (qv[i] == qv[b] && pr[i] < pr[b])))
                b = i;
        return b;
    endfunction : pick

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic tally(input bit bad, input string what);
        checks_done++;
        if (bad)
        begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : tally

    task automatic check_sel(input logic [2:0] got, input logic [2:0] exp);
        tally(got !== exp, "selection");
    endtask : check_sel

    task automatic check_sink(input logic [8:0] got, input logic [8:0] exp);
        tally(got !== exp, "sink output");
    endtask : check_sink

    task automatic check_count(input int got, input int exp, input int tol);
        tally(got > exp + tol || got < exp - tol, "pulse count");
    endtask : check_count

    // one random candidate set, then both selectors against the model
    task automatic sel_round(input int k);
        logic [15:0] a;
        logic [15:0] c;
        logic [3:0]  en;
        logic [1:0]  ais;
        int          st;
        int          s;
        rnd = lfsr(rnd);
        a = rnd;
        rnd = lfsr(rnd);
        c = rnd;
        st = a[12] ? 3 : 5;
        en = k == 0 ? 4'hf : a[11:8];
        ais = k == 0 ? 2'b11 : c[1:0] & a[1:0];
        for (int i = 0; i < 4; i++)
        begin
            qv[i] = (k == 0 || (i < 2 && ais[i])) ? 15 : int'(c[4*i +: 4]);
            pr[i] = (int'(a[15:13]) + st * i) % 8;
        end
        @(posedge clock_i);
        stm_ais <= ais;
        stm_ql <= c[7:0];
        e1_quality_i <= k == 0 ? 8'hff : c[15:8];
        ref_defect_i <= a[3:0] & a[7:4];
        ref_enable_i <= en;
        refout_enable_i <= en & a[7:4];
        ref_prio_i <= {3'(pr[3]), 3'(pr[2]), 3'(pr[1]), 3'(pr[0])};
        repeat (3) @(posedge clock_i);
        #1;
        s = pick(en);
        check_sel({2'b0, sys_internal_o}, 3'(s < 0));
        if (s >= 0) check_sel({1'b0, sys_sel_idx_o}, 3'(s));
        s = pick(en & a[7:4]);
        check_sel({2'b0, refout_valid_o}, 3'(s >= 0));
        if (s >= 0) check_sel({1'b0, refout_sel_idx_o}, 3'(s));
    endtask : sel_round

    // one sink byte strobe; f = {align, ais, overhead, frame start}
    task automatic strobe(input logic [7:0] d, input logic [3:0] f);
        @(posedge clock_i);
        {sink_align_en_i, sink_ais_i, sink_oh_i, sink_fs_i} <= f;
        adapted_data_i <= d;
        sink_clock_i <= 1'b1;
        @(posedge clock_i);
        sink_clock_i <= 1'b0;
        #1;
        if (!f[1]) check_sink({sink_fs_o, sink_data_o}, {f[3] ? prev == 8'hf6 && d == 8'h28 : f[0], f[2] ? 8'hff : d});
        prev = d;
    endtask : strobe

    // timing clocks between two frame starts, free running
    task automatic frame_check();
        int n;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge clock_i);
                #1;
                n += int'(dist_timing_clock_o);
            end while (dist_frame_start_o !== 1'b1);
        end
        check_count(n, 2430, 0);
    endtask : frame_check

    // every source ais code, oscillator rates over 1000 cycles
    task automatic osc_check();
        int n;
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clock_i);
            src_ais_sel_i <= 4'(k);
            n = 0;
            repeat (1000)
            begin
                @(posedge clock_i);
                #1;
                n += int'(src_ais_clock_o);
            end
            if (k >= 5) check_count(n, k > 10 ? 0 : int'(1000 * sts_pkg::AIS_KHZ[k - 5] / 250000), 2);
        end
    endtask : osc_check

    // background timing pulses for termination and source ais inputs
    always @(posedge clock_i)
    begin
        bgr = lfsr(bgr);
        {ho_ti_clock_i, tu_ti_clock_i, term_clock_i, term_fs_i} <= bgr[6:0];
        cycles <= cycles + 1;
        if (cycles == 70000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        clock_i = 1'b0;
        rst_i = 1'b1;
        {sink_clock_i, sink_fs_i, sink_oh_i, sink_align_en_i, sink_ais_i} = '0;
        {ref_defect_i, ref_enable_i, refout_enable_i, src_ais_sel_i} = '0;
        {e1_quality_i, adapted_data_i, stm_ql, ref_prio_i, stm_ais} = '0;
        {ho_ti_clock_i, tu_ti_clock_i, term_clock_i, term_fs_i} = '0;
        rnd = 16'h0058;
        bgr = 16'h0058;
        prev = 8'h00;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 40; k++) sel_round(k);
        @(posedge clock_i);
        ref_enable_i <= 4'h0;
        repeat (30)
        begin
            rnd = lfsr(rnd);
            strobe(rnd[15:8], {1'b0, rnd[2:0]});
        end
        strobe(8'hf6, 4'h8);
        strobe(8'h28, 4'h8);
        strobe(8'h28, 4'h8);
        fork
            frame_check();
            osc_check();
        join
        print_verdict();
    end
endmodule : sdh_sync_timing_select_distribute_bench
